// *** logic/asps_pkg.sv ***
// Purpose: constants and types shared by the serial parity and sampling block
// Assumes: classic Wishbone register access, one 50 MHz clock, synchronous reset
// Notes: offsets are byte addresses, one 32-bit word per register
package asps_pkg;

    // register byte offsets
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_DATA = 5'h04;
    localparam logic [4:0] OFF_CTRL1 = 5'h08;
    localparam logic [4:0] OFF_CTRL2 = 5'h0C;
    localparam logic [4:0] OFF_BAUD = 5'h10;

    // serial_status_register bits
    localparam int ST_TXE = 7;
    localparam int ST_TC = 6;
    localparam int ST_RXF = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OVR = 3;
    localparam int ST_NF = 2;
    localparam int ST_FE = 1;
    localparam int ST_PE = 0;
    localparam logic [7:0] STATUS_RST = 8'hC0;

    // serial_control_one bits
    localparam int C1_RX_BIT8 = 7;
    localparam int C1_TX_BIT8 = 6;
    localparam int C1_WORD9 = 4;
    localparam int C1_WAKE_ADDR = 3;
    localparam int C1_PCE = 2;
    localparam int C1_PODD = 1;
    localparam int C1_PIE = 0;

    // control two bits
    localparam int C2_TIE = 7;
    localparam int C2_TX_DONE_IRQ_ENABLE = 6;
    localparam int C2_RIE = 5;
    localparam int C2_IDLE_IRQ_ENABLE = 4;
    localparam int C2_TE = 3;
    localparam int C2_RE = 2;
    localparam int C2_MUTE = 1;

    // sampling: clock cycles per sample tick minus one (50 MHz / (16 * 9600))
    localparam logic [15:0] BAUD_RST = 16'h0144;
    localparam logic [4:0] SMP_FIRST = 5'h01;
    localparam logic [4:0] SMP_3 = 5'h03;
    localparam logic [4:0] SMP_5 = 5'h05;
    localparam logic [4:0] SMP_7 = 5'h07;
    localparam logic [4:0] SMP_8 = 5'h08;
    localparam logic [4:0] SMP_9 = 5'h09;
    localparam logic [4:0] SMP_10 = 5'h0A;
    localparam logic [4:0] SMP_LAST = 5'h10;
    localparam logic [7:0] IDLE_TICKS_SHORT = 8'hA0;
    localparam logic [7:0] IDLE_TICKS_LONG = 8'hB0;

    typedef enum logic [1:0] {
        RX_HUNT,
        RX_START,
        RX_DATA,
        RX_STOP
    } asps_rx_state_t;

endpackage

// *** logic/asps_serial.sv ***
// Purpose: asynchronous serial port with parity, 16x sampling, noise and one irq
// Assumes: rxd_i synchronous to clk_i; halt_i and wait_i levels from power control
// Notes: one shared sample tick drives both directions; wait_i has no effect
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module asps_serial #(
    parameter int WB_ADDR_W = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cpu_irq_mask_i,
    input wire logic halt_i,
    input wire logic wait_i,
    input wire logic rxd_i,
    output logic txd_o,
    output logic irq_o
);
    import asps_pkg::*;

    if (WB_ADDR_W < 5) begin : g_bad_addr
        $error("asps_serial: WB_ADDR_W must be at least 5");
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] status;
        logic status_seen;
        logic [15:0] baud;
        logic [15:0] div_cnt;
        logic [7:0] tx_data;
        logic [10:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_phase;
        logic tx_busy;
        logic txd;
        asps_rx_state_t rx_state;
        logic [2:0] rx_hist;
        logic [4:0] rx_cnt;
        logic [3:0] rx_bitn;
        logic [8:0] rx_sh;
        logic [1:0] rx_s;
        logic rx_nf;
        logic [7:0] rx_data;
        logic [7:0] idle_cnt;
        logic idle_armed;
    } asps_state_t;

    asps_state_t state_reg;
    asps_state_t state_next;

    logic req;
    logic [4:0] off;
    logic tick;
    logic samp;
    logic maj;
    logic disagree;
    logic [8:0] word;
    logic [8:0] body;
    logic [7:0] idle_len;
    logic any_irq;

    ////////////////////////////////////////////////////////////////////////
    // parity bit for the low 7 or 8 data bits; odd adds one
    function automatic logic calc_parity(input logic [8:0] w, input logic word9,
                                         input logic odd);
        logic p;
        p = word9 ? ^w[7:0] : ^w[6:0];
        return p ^ odd;
    endfunction

    // top data bit, skipping the parity slot
    function automatic logic top_data_bit(input logic [8:0] w, input logic word9,
                                          input logic parity_enable);
        logic b;
        if (parity_enable) begin
            b = word9 ? w[7] : w[6];
        end else begin
            b = word9 ? w[8] : w[7];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        off = wb_adr_i[4:0];
        tick = (state_reg.div_cnt == 16'h0000);
        samp = rxd_i;
        maj = 1'b0;
        disagree = 1'b0;
        word = 9'h000;
        body = 9'h000;
        idle_len = state_reg.ctrl1[C1_WORD9] ? IDLE_TICKS_LONG : IDLE_TICKS_SHORT;
        any_irq = 1'b0;

        // bus slave: answer one cycle after the request, unmapped reads zero
        state_next.ack = req;
        state_next.dat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            if (off == OFF_STATUS) begin
                state_next.dat[7:0] = state_reg.status;
            end else if (off == OFF_DATA) begin
                state_next.dat[7:0] = state_reg.rx_data;
            end else if (off == OFF_CTRL1) begin
                state_next.dat[7:0] = state_reg.ctrl1;
            end else if (off == OFF_CTRL2) begin
                state_next.dat[7:0] = state_reg.ctrl2;
            end else if (off == OFF_BAUD) begin
                state_next.dat[15:0] = state_reg.baud;
            end
        end

        // halt freezes every register except irq, which clears; bus still answers, no side effects
        if (!halt_i) begin
            if (req && !wb_we_i) begin
                if (off == OFF_STATUS) begin
                    state_next.status_seen = 1'b1;
                end else if (off == OFF_DATA && state_reg.status_seen) begin
                    state_next.status_seen = 1'b0;
                    state_next.status[ST_RXF] = 1'b0;
                    state_next.status[ST_IDLE] = 1'b0;
                    state_next.status[ST_OVR] = 1'b0;
                    state_next.status[ST_NF] = 1'b0;
                    state_next.status[ST_FE] = 1'b0;
                    state_next.status[ST_PE] = 1'b0;
                end
            end
            if (req && wb_we_i && wb_sel_i[0]) begin
                if (off == OFF_DATA) begin
                    state_next.tx_data = wb_dat_i[7:0];
                    if (state_reg.status_seen) begin
                        state_next.status_seen = 1'b0;
                        state_next.status[ST_TXE] = 1'b0;
                        state_next.status[ST_TC] = 1'b0;
                    end
                end else if (off == OFF_CTRL1) begin
                    // received ninth bit is read only
                    state_next.ctrl1 = {state_reg.ctrl1[C1_RX_BIT8], wb_dat_i[6:0]};
                end else if (off == OFF_CTRL2) begin
                    state_next.ctrl2 = wb_dat_i[7:0];
                end else if (off == OFF_BAUD) begin
                    state_next.baud[7:0] = wb_dat_i[7:0];
                end
            end
            if (req && wb_we_i && wb_sel_i[1] && off == OFF_BAUD) begin
                state_next.baud[15:8] = wb_dat_i[15:8];
            end

            // shared sample tick
            state_next.div_cnt = tick ? state_reg.baud : state_reg.div_cnt - 16'h0001;

            ////////////////////////////////////////////////////////////////
            // transmitter
            if (!state_reg.tx_busy) begin
                if (state_reg.ctrl2[C2_TE] && !state_reg.status[ST_TXE]) begin
                    body = {state_reg.ctrl1[C1_TX_BIT8], state_reg.tx_data};
                    if (state_reg.ctrl1[C1_PCE]) begin
                        // parity displaces the top written bit
                        if (state_reg.ctrl1[C1_WORD9]) begin
                            body[8] = calc_parity(body, 1'b1,
                                                  state_reg.ctrl1[C1_PODD]);
                        end else begin
                            body[7] = calc_parity(body, 1'b0,
                                                  state_reg.ctrl1[C1_PODD]);
                        end
                    end
                    if (state_reg.ctrl1[C1_WORD9]) begin
                        state_next.tx_shift = {1'b1, body, 1'b0};
                        state_next.tx_bits = 4'hB;
                    end else begin
                        state_next.tx_shift = {2'b11, body[7:0], 1'b0};
                        state_next.tx_bits = 4'hA;
                    end
                    state_next.tx_phase = 4'h0;
                    state_next.tx_busy = 1'b1;
                    state_next.txd = 1'b0;
                    state_next.status[ST_TXE] = 1'b1;
                end else begin
                    state_next.txd = 1'b1;
                end
            end else if (tick) begin
                state_next.tx_phase = state_reg.tx_phase + 4'h1;
                if (state_reg.tx_phase == 4'hF) begin
                    state_next.tx_shift = {1'b1, state_reg.tx_shift[10:1]};
                    state_next.tx_bits = state_reg.tx_bits - 4'h1;
                    state_next.txd = state_reg.tx_shift[1];
                    if (state_reg.tx_bits == 4'h1) begin
                        state_next.tx_busy = 1'b0;
                        state_next.txd = 1'b1;
                        state_next.status[ST_TC] = 1'b1;
                    end
                end
            end

            ////////////////////////////////////////////////////////////////
            // receiver, one sample per tick
            if (!state_reg.ctrl2[C2_RE]) begin
                state_next.rx_state = RX_HUNT;
                state_next.rx_hist = 3'b000;
                state_next.idle_cnt = 8'h00;
            end else if (tick) begin
                state_next.rx_hist = {state_reg.rx_hist[1:0], samp};
                if (state_reg.rx_cnt == SMP_8) begin
                    state_next.rx_s[0] = samp;
                end
                if (state_reg.rx_cnt == SMP_9) begin
                    state_next.rx_s[1] = samp;
                end
                maj = (state_reg.rx_s[0] & state_reg.rx_s[1])
                    | (state_reg.rx_s[0] & samp)
                    | (state_reg.rx_s[1] & samp);
                disagree = ~((state_reg.rx_s[0] == state_reg.rx_s[1])
                    && (state_reg.rx_s[1] == samp));
                if (state_reg.rx_cnt == SMP_LAST) begin
                    state_next.rx_cnt = SMP_FIRST;
                end else begin
                    state_next.rx_cnt = state_reg.rx_cnt + 5'h01;
                end

                case (state_reg.rx_state)
                    RX_HUNT: begin
                        if (samp) begin
                            if (state_reg.idle_cnt != 8'hFF) begin
                                state_next.idle_cnt = state_reg.idle_cnt + 8'h01;
                            end
                            if (state_reg.idle_armed && state_reg.idle_cnt == idle_len) begin
                                state_next.idle_armed = 1'b0;
                                if (!state_reg.ctrl2[C2_MUTE]) begin
                                    state_next.status[ST_IDLE] = 1'b1;
                                end else if (!state_reg.ctrl1[C1_WAKE_ADDR]) begin
                                    state_next.ctrl2[C2_MUTE] = 1'b0;
                                end
                            end
                        end else if (state_reg.rx_hist[0]) begin
                            // start edge restarts the sample count
                            state_next.rx_state = RX_START;
                            state_next.rx_cnt = 5'h02;
                            state_next.idle_cnt = 8'h00;
                            if (state_reg.rx_hist != 3'b111) begin
                                state_next.rx_nf = 1'b1;
                            end
                        end else begin
                            state_next.idle_cnt = 8'h00;
                        end
                    end
                    RX_START: begin
                        if (samp && (state_reg.rx_cnt == SMP_3 || state_reg.rx_cnt == SMP_5
                                     || state_reg.rx_cnt == SMP_7)) begin
                            state_next.rx_nf = 1'b1;
                        end
                        if (samp && state_reg.rx_cnt >= SMP_8 && state_reg.rx_cnt <= SMP_10) begin
                            state_next.rx_nf = 1'b1;
                        end
                        // false start: frame dropped, noise kept for next word
                        if (state_reg.rx_cnt == SMP_10 && maj) begin
                            state_next.rx_state = RX_HUNT;
                        end
                        if (state_reg.rx_cnt == SMP_LAST) begin
                            state_next.rx_state = RX_DATA;
                            state_next.rx_bitn = 4'h0;
                        end
                    end
                    RX_DATA: begin
                        if (state_reg.rx_cnt == SMP_10) begin
                            state_next.rx_sh = {maj, state_reg.rx_sh[8:1]};
                            if (disagree) begin
                                state_next.rx_nf = 1'b1;
                            end
                            state_next.rx_bitn = state_reg.rx_bitn + 4'h1;
                        end
                        if (state_reg.rx_cnt == SMP_LAST) begin
                            if (state_reg.rx_bitn == (state_reg.ctrl1[C1_WORD9] ? 4'h9 : 4'h8)) begin
                                state_next.rx_state = RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        // word ends at the stop bit's centre so the next start is seen
                        if (state_reg.rx_cnt == SMP_10) begin
                            state_next.rx_state = RX_HUNT;
                            state_next.rx_nf = 1'b0;
                            state_next.idle_armed = 1'b1;
                            state_next.idle_cnt = 8'h00;
                            word = state_reg.ctrl1[C1_WORD9] ? state_reg.rx_sh
                                                             : {1'b0, state_reg.rx_sh[8:1]};
                            if (state_reg.ctrl2[C2_MUTE]) begin
                                if (state_reg.ctrl1[C1_WAKE_ADDR]
                                    && top_data_bit(word, state_reg.ctrl1[C1_WORD9],
                                                    state_reg.ctrl1[C1_PCE])) begin
                                    state_next.ctrl2[C2_MUTE] = 1'b0;
                                end
                            end
                            if (!state_reg.ctrl2[C2_MUTE] || !state_next.ctrl2[C2_MUTE]) begin
                                if (state_reg.status[ST_RXF]) begin
                                    // held word is kept, overrun alone reported
                                    state_next.status[ST_OVR] = 1'b1;
                                end else begin
                                    // noise, framing and parity flags land with rx_full_flag
                                    state_next.status[ST_RXF] = 1'b1;
                                    state_next.rx_data = word[7:0];
                                    state_next.ctrl1[C1_RX_BIT8] = word[8];
                                    state_next.status[ST_NF] = state_reg.rx_nf
                                        | disagree;
                                    state_next.status[ST_FE] = ~maj;
                                    if (state_reg.ctrl1[C1_PCE]) begin
                                        if (calc_parity(word, state_reg.ctrl1[C1_WORD9],
                                                state_reg.ctrl1[C1_PODD])
                                            != (state_reg.ctrl1[C1_WORD9] ? word[8]
                                                                          : word[7])) begin
                                            state_next.status[ST_PE] = 1'b1;
                                        end
                                    end
                                end
                            end
                        end
                    end
                    default: begin
                        state_next.rx_state = RX_HUNT;
                    end
                endcase
            end

            ////////////////////////////////////////////////////////////////
            // single shared request line, gated by the processor mask
            any_irq = (state_reg.status[ST_TXE] & state_reg.ctrl2[C2_TIE])
                | (state_reg.status[ST_TC] & state_reg.ctrl2[C2_TX_DONE_IRQ_ENABLE])
                | ((state_reg.status[ST_RXF] | state_reg.status[ST_OVR])
                   & state_reg.ctrl2[C2_RIE])
                | (state_reg.status[ST_IDLE] & state_reg.ctrl2[C2_IDLE_IRQ_ENABLE])
                | (state_reg.status[ST_PE] & state_reg.ctrl1[C1_PIE]);
            state_next.irq = any_irq & ~cpu_irq_mask_i;
        end else begin
            // no serial event may wake from halt
            state_next.irq = 1'b0;
        end
        // wait_i deliberately unused: wait leaves the port running
        if (wait_i) begin
            state_next.irq = state_next.irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.status <= STATUS_RST;
            state_reg.baud <= BAUD_RST;
            state_reg.txd <= 1'b1;
            state_reg.rx_state <= RX_HUNT;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.dat;
    assign txd_o = state_reg.txd;
    assign irq_o = state_reg.irq;

endmodule // asps_serial

// *** verif/asps_remote.sv ***
// Purpose: remote serial end for the parity and sampling block
// Assumes: one sample tick per clock, so a bit is 16 clocks
// Notes: line idles high; glitch flips one clock mid data bit 0
`timescale 1ns/1ps
module asps_remote (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    initial line_o = 1'b1;
    task automatic send(input logic [8:0] body, input logic nine, input logic glitch);
        for (int i = 0; i < (nine ? 176 : 160); i++) begin
            @(posedge clk_i);
            line_o <= (i < 16) ? 1'b0 : (i >= (nine ? 160 : 144))
                || (body[i / 16 - 1] ^ (glitch && i == 24));
        end
    endtask
    task automatic recv(output logic [7:0] b);
        for (int n = 0; n < 400 && line_i; n++) @(posedge clk_i);
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_i);
            b[i] = line_i;
        end
    endtask
endmodule // asps_remote

// *** verif/asps_serial_properties.sv ***
// Purpose: port checks for the serial parity and sampling block
// Assumes: baud of one sample tick per clock once transmitting
// Notes: bound to every asps_serial instance
`timescale 1ns/1ps
module asps_serial_checker #(parameter int WB_ADDR_W = 5) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cpu_irq_mask_i,
    input wire logic halt_i,
    input wire logic txd_o,
    input wire logic irq_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o) else $error("late ack");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
    AST_IRQ_MASKED: assert property (cpu_irq_mask_i |=> !irq_o) else $error("masked irq");
    AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> !$past(cpu_irq_mask_i)
        && !$past(halt_i)) else $error("irq cause");
    AST_HALT_IRQ: assert property (halt_i |=> !irq_o) else $error("irq in halt");
    AST_HALT_TX: assert property (halt_i |=> $stable(txd_o)) else $error("tx in halt");
    AST_TX_BIT: assert property ($fell(txd_o) |-> !txd_o [*8]) else $error("short bit");
endmodule // asps_serial_checker
bind asps_serial asps_serial_checker #(.WB_ADDR_W(WB_ADDR_W)) u_chk (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .cpu_irq_mask_i, .halt_i, .txd_o, .irq_o);

// *** verif/asps_serial_tb.sv ***
// Purpose: register level regression of the serial parity and sampling block
// Assumes: baud register zero, one sample tick per clock
// Notes: wait_i high all run, since waiting must change nothing
`timescale 1ns/1ps
module asps_serial_tb;
    import asps_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic cpu_irq_mask_i = 1'b0, halt_i = 1'b0, wait_i = 1'b1;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic wb_ack_o, rxd_i, txd_o, irq_o;
    int miscompares = 0, cmp_count = 0;
    asps_serial dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_irq_mask_i, .halt_i, .wait_i, .rxd_i, .txd_o,
        .irq_o);
    asps_remote far (.clk_i, .line_i(txd_o), .line_o(rxd_i));
    initial forever #10 clk_i = ~clk_i;
    ////////////////////////////////////////
    task automatic complete_run;
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        miscompares += int'(g !== e);
        if (g !== e) $display("MISMATCH %0t got %h exp %h", $time, g, e);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        chk({7'h00, irq_o}, {7'h00, e});
    endtask
    task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h00_0000, d};
        for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        miscompares += int'(wb_ack_o !== 1'b1);
        if (wb_ack_o !== 1'b1) complete_run();
    endtask
    task automatic rx(input logic [8:0] body, input logic nine, input logic gl,
                      input logic [7:0] st);
        far.send(body, nine, gl);
        bus(1'b0, OFF_STATUS, 8'h00);
        chk(q[7:0], st);
        bus(1'b0, OFF_DATA, 8'h00);
        chk(q[7:0] & 8'h7F, {1'b0, body[6:0]});
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, OFF_STATUS, 8'h00);
        chk(q[7:0], 8'hC0);
        bus(1'b0, 5'h14, 8'h00);
        chk(q[7:0], 8'h00);
        bus(1'b1, OFF_BAUD, 8'h00);
        bus(1'b1, OFF_CTRL2, 8'h0C);
        // divider first runs out the reset baud count before ticking every clock
        repeat (400) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, OFF_CTRL1, {5'h00, !i[2], i[0], 1'b0});
            rx({1'b0, i[0] ^ i[1], 7'h35}, 1'b0, 1'b0, {7'h70, i[1] & !i[2]});
        end
        bus(1'b1, OFF_CTRL1, 8'h00);
        rx(9'h035, 1'b0, 1'b1, 8'hE4);
        bus(1'b1, OFF_CTRL1, 8'h16);
        rx(9'h135, 1'b1, 1'b0, 8'hE0);
        bus(1'b0, OFF_CTRL1, 8'h00);
        chk(q[7:0], 8'h96);
        bus(1'b1, OFF_CTRL1, 8'h0C);
        bus(1'b1, OFF_CTRL2, 8'h0E);
        far.send(9'h0B5, 1'b0, 1'b0);
        bus(1'b0, OFF_STATUS, 8'h00);
        chk(q[7:0], 8'hC0);
        rx(9'h0F5, 1'b0, 1'b0, 8'hE0);
        bus(1'b0, OFF_CTRL2, 8'h00);
        chk(q[7:0], 8'h0C);
        bus(1'b1, OFF_CTRL1, 8'h05);
        far.send(9'h0B5, 1'b0, 1'b0);
        irq_is(1'b1);
        cpu_irq_mask_i <= 1'b1;
        irq_is(1'b0);
        {cpu_irq_mask_i, halt_i} <= 2'b01;
        irq_is(1'b0);
        halt_i <= 1'b0;
        irq_is(1'b1);
        bus(1'b1, OFF_CTRL1, 8'h04);
        bus(1'b0, OFF_STATUS, 8'h00);
        bus(1'b1, OFF_DATA, 8'h8F);
        far.recv(q[7:0]);
        chk(q[7:0], 8'h0F);
        complete_run();
    end
endmodule // asps_serial_tb
